// >>> rtl/daq_pkg.sv
// Summary of operation
// - Enabled pacer emits one pulse per period
// - Pacer mode: pacer rising edge starts conversion
// - External mode: trigger rising edge starts conversion
// - External edges pass only while gate high
// - Counter 0 clock: internal 1 MHz or external
// - Event counting begins after gate triggered
// - Pulse mode drives train, software frequency
// - Sixteen inputs, pairs single or differential
// - Software sets each digital output level
// - Pacer is two cascaded 16-bit counters
package daq_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PACER_DIV1 = 8'h04;
    localparam logic [7:0] ADDR_PACER_DIV2 = 8'h08;
    localparam logic [7:0] ADDR_CNT_RELOAD = 8'h0C;
    localparam logic [7:0] ADDR_CNT_VALUE = 8'h10;
    localparam logic [7:0] ADDR_CHAN_PAIR = 8'h14;
    localparam logic [7:0] ADDR_DOUT = 8'h18;
    localparam logic [7:0] ADDR_DIN = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    // Control register fields
    localparam int CTRL_PACER_EN = 0;
    localparam int CTRL_TRIG_SEL = 1;
    localparam int CTRL_CNT_EXTCLK = 2;
    localparam int CTRL_CNT_MODE = 3;
    localparam int CTRL_CNT_EN = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [15:0] DIV_RESET = 16'h000A;
    localparam logic [15:0] CNT_RELOAD_RESET = 16'h0064;
    // Clock figures
    localparam int SYS_CLK_HZ = 20000000;
    localparam int INT_CLK_HZ = 1000000;
    localparam int PACER_CLK_HZ = 10000000;
    localparam int INT_DIV_CYC = SYS_CLK_HZ / INT_CLK_HZ;
    localparam int PACER_DIV_CYC = SYS_CLK_HZ / PACER_CLK_HZ;
    localparam int CHAN_PAIRS = 8;
    localparam int DIO_WIDTH = 16;
    typedef enum logic [2:0] {
        CNT_IDLE = 3'b001,
        CNT_ARMED = 3'b010,
        CNT_RUN = 3'b100
    } cnt_state_t;
endpackage : daq_pkg

// >>> rtl/edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
module edge_sync
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic din,
    output logic level,
    output logic rise
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;
    // Two flops then an edge detector on the settled copy only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end
    assign level = sync_ff;
    assign rise = sync_ff & ~last_ff;
endmodule // edge_sync
`default_nettype wire

// >>> rtl/pacer_timer.sv
`timescale 1ns/100ps
`default_nettype none
module pacer_timer
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic tick,
    input wire logic [15:0] div1,
    input wire logic [15:0] div2,
    output logic pacer_out
);
    logic [15:0] c1_ff;
    logic [15:0] c2_ff;
    logic pulse_ff;
    wire c1_wrap = tick && (c1_ff <= 16'h0001);
    wire c2_wrap = c1_wrap && (c2_ff <= 16'h0001);
    // Two cascaded 16-bit stages; second stage output is the pacer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            c1_ff <= 16'h0000;
            c2_ff <= 16'h0000;
            pulse_ff <= 1'b0;
        end
        else if (!enable)
        begin
            c1_ff <= div1;
            c2_ff <= div2;
            pulse_ff <= 1'b0;
        end
        else
        begin
            if (tick)
                c1_ff <= c1_wrap ? div1 : c1_ff - 16'h0001;
            if (c1_wrap)
                c2_ff <= c2_wrap ? div2 : c2_ff - 16'h0001;
            pulse_ff <= c2_wrap;
        end
    end
    assign pacer_out = pulse_ff;
endmodule // pacer_timer
`default_nettype wire

// >>> rtl/daq_trigger_counter_control.sv
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module daq_trigger_counter_control
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic external_trigger_in,
    input wire logic external_trigger_gate,
    input wire logic event_counter_clock_in,
    input wire logic event_counter_gate_in,
    output logic event_counter_out,
    output logic pacer_out,
    output logic conv_start,
    output logic [7:0] chan_pair_diff,
    input wire logic [15:0] digital_input_channels,
    output logic [15:0] digital_output_channels
);
    import daq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic [4:0] ctrl_ff;
    logic [15:0] div1_ff;
    logic [15:0] div2_ff;
    logic [15:0] reload_ff;
    logic [15:0] cnt_ff;
    logic [7:0] pair_ff;
    logic [15:0] dout_ff;
    logic [15:0] din_ff;
    logic [31:0] rdata_ff;
    logic wr_pend_ff;
    logic [7:0] waddr_ff;
    logic cnt_out_ff;
    logic start_ff;
    logic [15:0] conv_count_ff;
    cnt_state_t state_ff;
    cnt_state_t nxt_state;

    wire take = hsel && hready && htrans[1];
    wire take_rd = take && !hwrite;
    wire take_wr = take && hwrite;
    // Write data arrive one cycle after the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            waddr_ff <= 8'h00;
        end
        else
        begin
            wr_pend_ff <= take_wr;
            waddr_ff <= haddr;
        end
    end

    wire wr_ctrl = wr_pend_ff && (waddr_ff == ADDR_CTRL);
    wire wr_div1 = wr_pend_ff && (waddr_ff == ADDR_PACER_DIV1);
    wire wr_div2 = wr_pend_ff && (waddr_ff == ADDR_PACER_DIV2);
    wire wr_reload = wr_pend_ff && (waddr_ff == ADDR_CNT_RELOAD);
    wire wr_pair = wr_pend_ff && (waddr_ff == ADDR_CHAN_PAIR);
    wire wr_dout = wr_pend_ff && (waddr_ff == ADDR_DOUT);

    // Software-held configuration
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= CTRL_RESET;
            div1_ff <= DIV_RESET;
            div2_ff <= DIV_RESET;
            reload_ff <= CNT_RELOAD_RESET;
            pair_ff <= 8'h00;
            dout_ff <= 16'h0000;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= hwdata[4:0];
            if (wr_div1)
                div1_ff <= hwdata[15:0];
            if (wr_div2)
                div2_ff <= hwdata[15:0];
            if (wr_reload)
                reload_ff <= hwdata[15:0];
            if (wr_pair)
                pair_ff <= hwdata[7:0];
            if (wr_dout)
                dout_ff <= hwdata[15:0];
        end
    end

    // Read mux; unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        case (haddr)
            ADDR_CTRL: rd_mux = {27'h0, ctrl_ff};
            ADDR_PACER_DIV1: rd_mux = {16'h0, div1_ff};
            ADDR_PACER_DIV2: rd_mux = {16'h0, div2_ff};
            ADDR_CNT_RELOAD: rd_mux = {16'h0, reload_ff};
            ADDR_CNT_VALUE: rd_mux = {16'h0, cnt_ff};
            ADDR_CHAN_PAIR: rd_mux = {24'h0, pair_ff};
            ADDR_DOUT: rd_mux = {16'h0, dout_ff};
            ADDR_DIN: rd_mux = {16'h0, din_ff};
            ADDR_STATUS: rd_mux = {conv_count_ff, 13'h0, state_ff};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_ff <= 32'h0000_0000;
        else if (take_rd)
            rdata_ff <= rd_mux;
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0;
    assign chan_pair_diff = pair_ff;
    assign digital_output_channels = dout_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Field input synchronisers
    logic trg_lvl;
    logic trg_rise;
    logic gate_lvl;
    logic ecg_lvl;
    logic ecg_rise;
    logic ecc_lvl;
    logic ecc_rise;

    edge_sync u_trg (.hclk(hclk), .hresetn(hresetn), .din(external_trigger_in),
        .level(trg_lvl), .rise(trg_rise));
    edge_sync u_gate (.hclk(hclk), .hresetn(hresetn), .din(external_trigger_gate),
        .level(gate_lvl), .rise());
    edge_sync u_ecg (.hclk(hclk), .hresetn(hresetn), .din(event_counter_gate_in),
        .level(ecg_lvl), .rise(ecg_rise));
    edge_sync u_ecc (.hclk(hclk), .hresetn(hresetn), .din(event_counter_clock_in),
        .level(ecc_lvl), .rise(ecc_rise));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            din_ff <= 16'h0000;
        else
            din_ff <= digital_input_channels;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prescalers: 10 MHz pacer tick and 1 MHz counter tick
    function automatic logic [4:0] wrap_inc(input logic [4:0] v, input int lim);
        wrap_inc = (v >= 5'(lim - 1)) ? 5'h00 : v + 5'h01;
    endfunction

    logic [4:0] pdiv_ff;
    logic [4:0] idiv_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pdiv_ff <= 5'h00;
            idiv_ff <= 5'h00;
        end
        else
        begin
            pdiv_ff <= wrap_inc(pdiv_ff, PACER_DIV_CYC);
            idiv_ff <= wrap_inc(idiv_ff, INT_DIV_CYC);
        end
    end
    wire pacer_tick = (pdiv_ff == 5'h00);
    wire int_tick = (idiv_ff == 5'h00);

    ////////////////////////////////////////////////////////////////////////////////
    // Pacer and conversion start
    logic pacer_q;
    logic pacer_last_ff;
    pacer_timer u_pacer (.hclk(hclk), .hresetn(hresetn), .enable(ctrl_ff[CTRL_PACER_EN]),
        .tick(pacer_tick), .div1(div1_ff), .div2(div2_ff), .pacer_out(pacer_q));
    assign pacer_out = pacer_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pacer_last_ff <= 1'b0;
        else
            pacer_last_ff <= pacer_q;
    end
    wire pacer_rise = pacer_q & ~pacer_last_ff;
    // Unselected source is ignored, gate low blocks external edges
    wire ext_start = ctrl_ff[CTRL_TRIG_SEL] && trg_rise && gate_lvl;
    wire pac_start = !ctrl_ff[CTRL_TRIG_SEL] && pacer_rise;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_ff <= 1'b0;
            conv_count_ff <= 16'h0000;
        end
        else
        begin
            start_ff <= ext_start || pac_start;
            if (ext_start || pac_start)
                conv_count_ff <= conv_count_ff + 16'h0001;
        end
    end
    assign conv_start = start_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter 0: event counting (mode 0) or pulse output (mode 1)
    // External clock is sampled, so it tracks up to a quarter of hclk only
    wire cnt_tick = ctrl_ff[CTRL_CNT_EXTCLK] ? ecc_rise : int_tick;
    wire pulse_mode = ctrl_ff[CTRL_CNT_MODE];
    wire cnt_en = ctrl_ff[CTRL_CNT_EN];

    always_comb
    begin
        case (state_ff)
            CNT_IDLE: nxt_state = cnt_en ? (pulse_mode ? CNT_RUN : CNT_ARMED) : CNT_IDLE;
            CNT_ARMED: nxt_state = !cnt_en ? CNT_IDLE : (ecg_rise ? CNT_RUN : CNT_ARMED);
            CNT_RUN: nxt_state = cnt_en ? CNT_RUN : CNT_IDLE;
            default: nxt_state = CNT_IDLE;
        endcase
    end

    wire cnt_zero = (cnt_ff <= 16'h0001);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= CNT_IDLE;
            cnt_ff <= 16'h0000;
            cnt_out_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff == CNT_IDLE)
            begin
                cnt_ff <= pulse_mode ? reload_ff : 16'h0000;
                cnt_out_ff <= 1'b0;
            end
            else if (state_ff == CNT_RUN && cnt_tick)
            begin
                if (!pulse_mode)
                    cnt_ff <= cnt_ff + 16'h0001;
                else if (cnt_zero)
                begin
                    cnt_ff <= reload_ff;
                    cnt_out_ff <= ~cnt_out_ff;
                end
                else
                    cnt_ff <= cnt_ff - 16'h0001;
            end
        end
    end
    assign event_counter_out = cnt_out_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic unused_lvls;
    assign unused_lvls = trg_lvl ^ ecg_lvl ^ ecc_lvl ^ hsize[0] ^ htrans[0];

    ext_gate_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[CTRL_TRIG_SEL] && !gate_lvl) |=> !start_ff)
        else $error("start while gate low");
    ext_edge_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[CTRL_TRIG_SEL] && $rose(trg_lvl) && gate_lvl) |=> start_ff)
        else $error("external edge lost");
    pacer_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_ff[CTRL_TRIG_SEL] && $rose(pacer_q)) |=> start_ff)
        else $error("pacer edge lost");
    unselected_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_ff[CTRL_TRIG_SEL] && !pacer_rise) |=> !start_ff)
        else $error("start from unselected source");
    single_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start_ff |=> !start_ff)
        else $error("start longer than one cycle");
    pacer_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_ff[CTRL_PACER_EN] |=> !pacer_q)
        else $error("pacer pulse while off");
    armed_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == CNT_ARMED) |=> (cnt_ff == 16'h0000))
        else $error("counting before gate");
    pulse_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == CNT_IDLE) |=> !cnt_out_ff)
        else $error("pulse output while idle");
    dout_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_dout |=> (digital_output_channels == $past(hwdata[15:0])))
        else $error("digital output not written");

    ext_trig_c: cover property (@(posedge hclk) disable iff (!hresetn) ext_start);
    pacer_trig_c: cover property (@(posedge hclk) disable iff (!hresetn) pac_start);
    gate_arm_c: cover property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == CNT_ARMED) ##1 (state_ff == CNT_RUN));
    pulse_toggle_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(cnt_out_ff));
endmodule // daq_trigger_counter_control
`default_nettype wire

// >>> tb/field_model.sv
`timescale 1ns/100ps
`default_nettype none
// Field side of the connector: trigger source with its gate, counter clock and gate
module field_model
(
    input wire logic hclk,
    output logic trig,
    output logic gate,
    output logic cnt_clk,
    output logic cnt_gate
);
    // All field lines idle low, gate tied to ground until told otherwise
    initial
    begin
        trig = 1'b0;
        gate = 1'b0;
        cnt_clk = 1'b0;
        cnt_gate = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One trigger pulse, held 4 cycles so the two sync flops surely catch it
    task automatic fire();
        @(posedge hclk);
        trig <= 1'b1;
        repeat (4) @(posedge hclk);
        trig <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask
    // Gate is a level; low stands for the tie to digital ground
    task automatic set_gate(input logic v);
        @(posedge hclk);
        gate <= v;
    endtask
    // Counter clock at 2.5 MHz; the sampled input is only good to about 5 MHz
    task automatic clocks(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge hclk);
            cnt_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            cnt_clk <= 1'b0;
        end
        repeat (6) @(posedge hclk);
    endtask
    // Rising edge on the counter gate
    task automatic arm();
        @(posedge hclk);
        cnt_gate <= 1'b1;
        repeat (4) @(posedge hclk);
        cnt_gate <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
endmodule // field_model
`default_nettype wire

// >>> tb/daq_trigger_counter_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module daq_trigger_counter_control_bench;
    import daq_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, trig, gate, cclk, cgate;
    logic event_counter_out, pacer_out, conv_start;
    logic [7:0] haddr, chan_pair_diff;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q, v0, v1, exp_conv;
    logic [15:0] digital_input_channels, digital_output_channels;
    int errors = 0, n_compared = 0, n_conv = 0, n_pace = 0, c;
    // Reset rows first, then writes read back; the last two hit unmapped and read-only places
    row_t rows[13] = '{
        '{1'b0, ADDR_CTRL, 32'h0, 32'h0}, '{1'b0, ADDR_PACER_DIV1, 32'h0, 32'h0000000A},
        '{1'b0, ADDR_PACER_DIV2, 32'h0, 32'h0000000A}, '{1'b0, ADDR_CNT_RELOAD, 32'h0, 32'h00000064},
        '{1'b0, ADDR_STATUS, 32'h0, 32'h00000001}, '{1'b0, ADDR_DIN, 32'h0, 32'h0000C3A5},
        '{1'b1, ADDR_PACER_DIV1, 32'h00012345, 32'h00002345}, '{1'b1, ADDR_PACER_DIV2, 32'h00020004, 32'h4},
        '{1'b1, ADDR_CNT_RELOAD, 32'h00000003, 32'h3}, '{1'b1, ADDR_CHAN_PAIR, 32'hFFFFFFA5, 32'hA5},
        '{1'b1, ADDR_DOUT, 32'hFFFF5A3C, 32'h5A3C}, '{1'b1, 8'h3C, 32'hFFFFFFFF, 32'h0},
        '{1'b1, ADDR_DIN, 32'h0, 32'h0000C3A5}};
    daq_trigger_counter_control u_daq_trigger_counter_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_trigger_in(trig),
        .external_trigger_gate(gate), .event_counter_clock_in(cclk), .event_counter_gate_in(cgate),
        .event_counter_out(event_counter_out), .pacer_out(pacer_out), .conv_start(conv_start),
        .chan_pair_diff(chan_pair_diff), .digital_input_channels(digital_input_channels),
        .digital_output_channels(digital_output_channels));
    field_model u_field_model (.hclk(hclk), .trig(trig), .gate(gate), .cnt_clk(cclk), .cnt_gate(cgate));
    ////////////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // Tally every conversion start and pacer pulse
    always @(posedge hclk)
    begin
        if (conv_start === 1'b1) n_conv++;
        if (pacer_out === 1'b1) n_pace++;
    end
    // Hang guard; the whole run needs well under 4000 cycles
    initial
    begin
        repeat (10000) @(posedge hclk);
        errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One single AHB-Lite word transfer; waits on ready rather than assuming a latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Cycles from one rising edge to the next of pacer_out or the counter output
    task automatic gap(input bit pick, output int n);
        int ph;
        ph = 0;
        n = 0;
        while (ph < 4)
        begin
            @(posedge hclk);
            if (ph >= 2) n++;
            if ((pick ? event_counter_out : pacer_out) === ph[0]) ph++;
        end
    endtask
    function automatic logic [31:0] absd(input logic [31:0] a, input logic [31:0] b);
        return (a > b) ? a - b : b - a;
    endfunction
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        digital_input_channels = 16'hC3A5;
        repeat (3) @(posedge hclk);
        `CHK("reset outputs", 28'h0, {pacer_out, conv_start, event_counter_out, hresp, chan_pair_diff,
            digital_output_channels})
        hresetn <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, q);
            bus(1'b0, rows[i].a, 32'h0, q);
            `CHK("register", rows[i].e, q)
        end
        `CHK("pair mode", 8'hA5, chan_pair_diff)
        `CHK("dout", 16'h5A3C, digital_output_channels)
        // Pacer trigger; an external edge with the gate high must not add a start
        bus(1'b1, ADDR_PACER_DIV1, 32'h2, q);
        bus(1'b1, ADDR_PACER_DIV2, 32'h3, q);
        n_conv = 0;
        n_pace = 0;
        bus(1'b1, ADDR_CTRL, 32'h1, q);
        gap(1'b0, c);
        `CHK("pacer period", 2 * 3 * PACER_DIV_CYC, c)
        u_field_model.set_gate(1'b1);
        u_field_model.fire();
        bus(1'b1, ADDR_CTRL, 32'h0, q);
        repeat (10) @(posedge hclk);
        `CHK("pacer starts", n_pace, n_conv)
        exp_conv = n_pace;
        // External trigger with the pacer still pulsing: gate off, then three edges
        bus(1'b1, ADDR_CTRL, 32'h3, q);
        u_field_model.set_gate(1'b0);
        u_field_model.fire();
        `CHK("gated off", exp_conv, n_conv)
        u_field_model.set_gate(1'b1);
        repeat (3) u_field_model.fire();
        exp_conv = exp_conv + 3;
        // Pacer off with external still selected, so a pulse on the write edge cannot add a start
        bus(1'b1, ADDR_CTRL, 32'h2, q);
        repeat (10) @(posedge hclk);
        `CHK("ext starts", exp_conv, n_conv)
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        `CHK("start count", exp_conv[15:0], q[31:16])
        // Event counting from the external clock: nothing before the gate edge
        bus(1'b1, ADDR_CTRL, 32'h14, q);
        bus(1'b0, ADDR_CNT_VALUE, 32'h0, v0);
        u_field_model.clocks(3);
        bus(1'b0, ADDR_CNT_VALUE, 32'h0, v1);
        `CHK("no count ungated", v0, v1)
        u_field_model.arm();
        bus(1'b0, ADDR_CNT_VALUE, 32'h0, v0);
        u_field_model.clocks(5);
        bus(1'b0, ADDR_CNT_VALUE, 32'h0, v1);
        `CHK("ext events", 32'h5, absd(v0, v1))
        // Internal 1 MHz source over ten ticks
        bus(1'b1, ADDR_CTRL, 32'h0, q);
        bus(1'b1, ADDR_CTRL, 32'h10, q);
        u_field_model.arm();
        bus(1'b0, ADDR_CNT_VALUE, 32'h0, v0);
        repeat (10 * INT_DIV_CYC) @(posedge hclk);
        bus(1'b0, ADDR_CNT_VALUE, 32'h0, v1);
        `CHK("int ticks", 1'b1, absd(v0, v1) inside {[9:11]})
        // Pulse output: toggles every reload ticks of the internal source
        bus(1'b1, ADDR_CTRL, 32'h18, q);
        gap(1'b1, c);
        `CHK("pulse period", 2 * 3 * INT_DIV_CYC, c)
        // Reset in mid-run, with the pulse train still toggling
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK("mid reset outputs", 28'h0, {pacer_out, conv_start, event_counter_out, hresp, chan_pair_diff,
            digital_output_channels})
        hresetn <= 1'b1;
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        `CHK("status after reset", 32'h00000001, q)
        bus(1'b0, ADDR_CTRL, 32'h0, q);
        `CHK("ctrl after reset", 32'h00000000, q)
        final_report();
    end
endmodule // daq_trigger_counter_control_bench
`default_nettype wire
